// >>> fesis_flash_model.sv
`timescale 1ns/1ps
module fesis_flash_model
    import fesis_pkg::*;
#(
    parameter int P_SEC_READS = 20,
    parameter int P_CHIP_READS = 40,
    parameter logic [DATA_W-1:0] P_MAKER = 16'h00a5, // arbitrary value
    parameter logic [DATA_W-1:0] P_PART = 16'h005a // arbitrary value
) (
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_dq,
    input wire logic i_ce_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_hang,
    output logic [DATA_W-1:0] o_dq
);
    logic [47:0] hd = '0;
    logic [71:0] ha = '0;
    int busy_left = 0;
    logic id_mode = 1'b0;
    logic lock_on = 1'b0;
    logic [7:0] last_kind = 8'h00;
    logic [ADDR_W-1:0] last_addr = '0;
    logic tog = 1'b0;
    logic [DATA_W-1:0] rd_val;
    logic [DATA_W-1:0] last_out = '0;
    wire rd_n = i_ce_n | i_oe_n;
    // decode command writes, low byte and low address only
    always @(posedge i_we_n) if (!i_ce_n) begin
        hd = {hd[39:0], i_dq[7:0]};
        ha = {ha[59:0], i_addr[11:0]};
        if (hd[47:8] == 40'haa5580aa55 &&
            ha[71:12] == 60'h5552aa5555552aa) begin
            if (hd[7:0] == 8'h10 && ha[11:0] == 12'h555) begin
                last_kind = 8'h10;
                busy_left = P_CHIP_READS;
            end else if (hd[7:0] == 8'h30) begin
                last_kind = 8'h30;
                last_addr = i_addr;
                busy_left = P_SEC_READS;
            end else if (hd[7:0] == 8'h60) lock_on = 1'b1;
        end
        if (hd[23:0] == 24'haa5590 && ha[35:0] == 36'h5552aa555) begin
            id_mode = 1'b1;
        end
        if (hd[7:0] == 8'hf0) id_mode = 1'b0;
    end
    // each read strobe while busy flips the toggle bit
    always @(negedge rd_n) if (busy_left > 0) begin
        tog = ~tog;
        if (!i_hang) busy_left--;
    end
    // read data: status while busy, codes in id mode, else erased array
    always_comb begin
        if (busy_left > 0) rd_val = {9'h000, tog, 6'h00};
        else if (id_mode && i_addr == 19'h00000) rd_val = P_MAKER;
        else if (id_mode && i_addr == 19'h00001) rd_val = P_PART;
        else rd_val = 16'hffff;
    end
    // a released bus shows the inverse of the last value
    always @(rd_n or rd_val) if (!rd_n) last_out = rd_val;
    assign o_dq = rd_n ? ~last_out : rd_val;
endmodule : fesis_flash_model

// >>> fesis_host.sv
`timescale 1ns/1ps
module fesis_host
    import fesis_pkg::*;
#(
    parameter int P_SEC_SMALL_TMO_CYC = SEC_SMALL_MAX_CYC,
    parameter int P_SEC_LARGE_TMO_CYC = SEC_LARGE_MAX_CYC,
    parameter int P_CHIP_TMO_CYC = CHIP_MAX_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire fesis_op_t i_cmd_op,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic i_small_sector,
    input wire logic i_long_exit,
    output logic o_cmd_ready,
    output logic o_busy,
    output logic o_done,
    output logic o_timeout,
    output logic [DATA_W-1:0] o_maker_code,
    output logic [DATA_W-1:0] o_part_code,
    output logic [ADDR_W-1:0] o_flash_addr,
    output logic [DATA_W-1:0] o_dq_out,
    output logic o_dq_oe,
    input wire logic [DATA_W-1:0] i_dq_in,
    output logic o_ce_n,
    output logic o_oe_n,
    output logic o_we_n
);
    fesis_state_t state, next_state;
    fesis_phase_t phase, next_phase;
    fesis_op_t op, next_op;
    logic [ADDR_W-1:0] addr, next_addr;
    logic small_sec, next_small_sec;
    logic long_exit, next_long_exit;
    logic [IDX_W-1:0] idx, next_idx;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [TMO_W-1:0] tmo, next_tmo;
    logic prev_tog, next_prev_tog;
    logic have_prev, next_have_prev;
    logic tog_same, next_tog_same;
    logic [ADDR_W-1:0] next_flash_addr;
    logic [DATA_W-1:0] next_dq_out;
    logic next_dq_oe, next_ce_n, next_oe_n, next_we_n;
    logic next_done, next_timeout;
    logic [DATA_W-1:0] next_maker, next_part;
    logic [DATA_W-1:0] dq_sync1, dq_sync2;
    logic [IDX_W-1:0] seq_len;
    logic [CMD_ADDR_W-1:0] seq_addr;
    logic [CMD_DATA_W-1:0] seq_data;
    logic [TMO_W-1:0] tmo_limit;
    logic tog_now;

    // length of the write sequence for the current phase
    assign seq_len = (phase == PH_EXIT) ?
        (long_exit ? SHORT_SEQ_LEN : EXIT_SHORT_LEN) :
        ((op == OP_READ_ID) ? SHORT_SEQ_LEN : LONG_SEQ_LEN);

    // command cycle address and data for the current step
    always_comb begin
        seq_addr = UNLOCK_ADDR1;
        seq_data = CMD_UNLOCK1;
        if (phase == PH_EXIT && !long_exit) begin
            seq_data = CMD_ID_EXIT;
        end else begin
            unique case (idx)
                3'h0, 3'h3: seq_data = CMD_UNLOCK1;
                3'h1, 3'h4: begin
                    seq_addr = UNLOCK_ADDR2;
                    seq_data = CMD_UNLOCK2;
                end
                3'h2: begin
                    if (phase == PH_EXIT) begin
                        seq_data = CMD_ID_EXIT;
                    end else if (op == OP_READ_ID) begin
                        seq_data = CMD_ID_ENTRY;
                    end else begin
                        seq_data = CMD_ERASE_SETUP;
                    end
                end
                default: begin
                    unique case (op)
                        OP_CHIP_ERASE: seq_data = CMD_CHIP_ERASE;
                        OP_SECTOR_ERASE: seq_data = CMD_SECTOR_ERASE;
                        default: seq_data = CMD_LOCKDOWN;
                    endcase
                end
            endcase
        end
    end

    // erase time limit for the running operation
    assign tmo_limit = (op == OP_CHIP_ERASE) ?
        TMO_W'(P_CHIP_TMO_CYC) :
        (small_sec ? TMO_W'(P_SEC_SMALL_TMO_CYC) :
        TMO_W'(P_SEC_LARGE_TMO_CYC));

    assign tog_now = dq_sync2[TOGGLE_BIT];

    // sequencer next-state logic
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_op = op;
        next_addr = addr;
        next_small_sec = small_sec;
        next_long_exit = long_exit;
        next_idx = idx;
        next_cnt = cnt;
        next_tmo = tmo;
        next_prev_tog = prev_tog;
        next_have_prev = have_prev;
        next_tog_same = tog_same;
        next_flash_addr = o_flash_addr;
        next_dq_out = o_dq_out;
        next_done = 1'b0;
        next_timeout = o_timeout;
        next_maker = o_maker_code;
        next_part = o_part_code;
        if (phase == PH_POLL && state != ST_IDLE && state != ST_DONE) begin
            next_tmo = tmo + TMO_W'(1);
        end
        unique case (state)
            ST_IDLE: begin
                if (i_cmd_valid) begin
                    next_op = i_cmd_op;
                    next_addr = i_cmd_addr;
                    next_small_sec = i_small_sector;
                    next_long_exit = i_long_exit;
                    next_phase = PH_CMD;
                    next_idx = '0;
                    next_timeout = 1'b0;
                    next_state = ST_WSETUP;
                end
            end
            ST_WSETUP: next_state = ST_WLOW;
            ST_WLOW: next_state = ST_WHIGH;
            ST_WHIGH: begin
                if (idx + IDX_W'(1) < seq_len) begin
                    next_idx = idx + IDX_W'(1);
                    next_state = ST_WSETUP;
                end else if (phase == PH_EXIT || op == OP_LOCKDOWN) begin
                    next_state = ST_DONE;
                end else if (op == OP_READ_ID) begin
                    next_phase = PH_ID_MAKER;
                    next_cnt = '0;
                    next_flash_addr = ID_MAKER_ADDR;
                    next_state = ST_RLOW;
                end else begin
                    next_phase = PH_POLL;
                    next_tmo = '0;
                    next_have_prev = 1'b0;
                    next_cnt = '0;
                    next_flash_addr = addr;
                    next_state = ST_RLOW;
                end
            end
            ST_RLOW: begin
                next_cnt = cnt + CNT_W'(1);
                if (cnt + CNT_W'(1) >= RD_LOW_CYC) begin
                    next_cnt = '0;
                    next_state = ST_RGAP;
                    unique case (phase)
                        PH_ID_MAKER: next_maker = dq_sync2;
                        PH_ID_PART: next_part = dq_sync2;
                        default: begin
                            next_tog_same = have_prev && (prev_tog == tog_now);
                            next_prev_tog = tog_now;
                            next_have_prev = 1'b1;
                        end
                    endcase
                end
            end
            ST_RGAP: begin
                next_cnt = cnt + CNT_W'(1);
                if (cnt + CNT_W'(1) >= GAP_CYC) begin
                    next_cnt = '0;
                    unique case (phase)
                        PH_ID_MAKER: begin
                            next_phase = PH_ID_PART;
                            next_flash_addr = ID_PART_ADDR;
                            next_state = ST_RLOW;
                        end
                        PH_ID_PART: begin
                            next_phase = PH_EXIT;
                            next_idx = '0;
                            next_state = ST_WSETUP;
                        end
                        default: begin
                            if (tog_same) begin
                                next_state = ST_DONE;
                            end else if (tmo >= tmo_limit) begin
                                next_timeout = 1'b1;
                                next_state = ST_DONE;
                            end else begin
                                next_state = ST_RLOW;
                            end
                        end
                    endcase
                end
            end
            ST_DONE: begin
                next_done = 1'b1;
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        if (state == ST_WSETUP) begin
            next_dq_out = {{(DATA_W-CMD_DATA_W){1'b0}}, seq_data};
            next_flash_addr = {{(ADDR_W-CMD_ADDR_W){1'b0}}, seq_addr};
            if (phase == PH_CMD && op == OP_SECTOR_ERASE &&
                idx == LONG_SEQ_LEN - IDX_W'(1)) begin
                next_flash_addr = addr;
            end
        end
        next_ce_n = !(next_state == ST_WSETUP || next_state == ST_WLOW ||
            next_state == ST_WHIGH || next_state == ST_RLOW);
        next_we_n = !(next_state == ST_WLOW);
        next_oe_n = !(next_state == ST_RLOW);
        next_dq_oe = next_state == ST_WSETUP || next_state == ST_WLOW ||
            next_state == ST_WHIGH;
    end

    // handshake and status seen by the requester
    assign o_cmd_ready = (state == ST_IDLE);
    assign o_busy = (state != ST_IDLE);

    // control state and pin strobes, parked idle by reset
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state <= ST_IDLE;
            phase <= PH_CMD;
            op <= OP_CHIP_ERASE;
            idx <= '0;
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            o_dq_oe <= 1'b0;
            o_done <= 1'b0;
            o_timeout <= 1'b0;
        end else begin
            state <= next_state;
            phase <= next_phase;
            op <= next_op;
            idx <= next_idx;
            o_ce_n <= next_ce_n;
            o_oe_n <= next_oe_n;
            o_we_n <= next_we_n;
            o_dq_oe <= next_dq_oe;
            o_done <= next_done;
            o_timeout <= next_timeout;
        end
    end

    // data path and counters, always loaded before use; the data pins
    // pass two flip-flops before the sequencer reads them
    always_ff @(posedge i_ref_clk) begin
        addr <= next_addr;
        small_sec <= next_small_sec;
        long_exit <= next_long_exit;
        cnt <= next_cnt;
        tmo <= next_tmo;
        prev_tog <= next_prev_tog;
        have_prev <= next_have_prev;
        tog_same <= next_tog_same;
        o_flash_addr <= next_flash_addr;
        o_dq_out <= next_dq_out;
        o_maker_code <= next_maker;
        o_part_code <= next_part;
        dq_sync1 <= i_dq_in;
        dq_sync2 <= dq_sync1;
    end
endmodule : fesis_host

// >>> fesis_host_properties.sv
`timescale 1ns/1ps
module fesis_host_props
    import fesis_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cmd_valid,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic o_cmd_ready,
    input wire logic o_done,
    input wire logic o_timeout,
    input wire logic [ADDR_W-1:0] o_flash_addr,
    input wire logic [DATA_W-1:0] o_dq_out,
    input wire logic o_dq_oe,
    input wire logic o_ce_n,
    input wire logic o_oe_n,
    input wire logic o_we_n
);
    logic [ADDR_W-1:0] req_addr;
    logic [ADDR_W-1:0] next_req_addr;
    logic [7:0] wr_byte;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // remember the address of the last accepted request
    always_comb begin
        next_req_addr = req_addr;
        if (i_cmd_valid && o_cmd_ready) next_req_addr = i_cmd_addr;
    end
    always_ff @(posedge i_ref_clk) begin
        req_addr <= next_req_addr;
    end
    assign wr_byte = o_dq_out[7:0];
    a_reset_idle: assert property (disable iff (1'b0)
        i_rst |=> o_ce_n && o_oe_n && o_we_n && !o_dq_oe)
        else $error("bus not idle after reset");
    a_write_no_read: assert property (
        !o_we_n |-> o_oe_n && !o_ce_n && o_dq_oe)
        else $error("output enable low during write");
    a_read_no_drive: assert property (
        !o_oe_n |-> o_we_n && !o_dq_oe)
        else $error("host drives data during read");
    a_read_low_len: assert property (
        $fell(o_oe_n) |-> !o_oe_n [*3])
        else $error("read strobe too short");
    a_poll_addr_hold: assert property (
        !o_oe_n && $past(!o_oe_n) |-> $stable(o_flash_addr))
        else $error("address moved during read");
    a_wr_data_hold: assert property (
        !o_we_n && $past(!o_we_n) |-> $stable(o_dq_out))
        else $error("data moved during write");
    a_chip_addr: assert property (
        !o_we_n && wr_byte == CMD_CHIP_ERASE
        |-> o_flash_addr[CMD_ADDR_W-1:0] == UNLOCK_ADDR1)
        else $error("chip erase final write at wrong address");
    a_sector_addr: assert property (
        !o_we_n && wr_byte == CMD_SECTOR_ERASE
        |-> o_flash_addr[18:12] == req_addr[18:12])
        else $error("sector erase at wrong sector");
    a_id_entry_addr: assert property (
        !o_we_n && wr_byte == CMD_ID_ENTRY
        |-> o_flash_addr[CMD_ADDR_W-1:0] == UNLOCK_ADDR1)
        else $error("id entry at wrong address");
    c_chip: cover property (!o_we_n && wr_byte == CMD_CHIP_ERASE);
    c_sector: cover property (!o_we_n && wr_byte == CMD_SECTOR_ERASE);
    c_done: cover property (o_done);
    c_timeout: cover property (o_timeout);
endmodule : fesis_host_props
bind fesis_host fesis_host_props u_props (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
    .i_cmd_addr(i_cmd_addr), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
    .o_timeout(o_timeout), .o_flash_addr(o_flash_addr),
    .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n), .o_we_n(o_we_n)
);

// >>> fesis_host_test.sv
`timescale 1ns/1ps
module fesis_host_test
    import fesis_pkg::*;
;
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cmd_valid = 1'b0;
    fesis_op_t i_cmd_op = OP_CHIP_ERASE;
    logic [ADDR_W-1:0] i_cmd_addr = '0;
    logic i_small_sector = 1'b0;
    logic i_long_exit = 1'b0;
    logic hang = 1'b0;
    logic o_cmd_ready, o_busy, o_done, o_timeout, o_dq_oe;
    logic o_ce_n, o_oe_n, o_we_n, saw_busy;
    logic [DATA_W-1:0] o_maker_code, o_part_code, o_dq_out, dq_in, fl_dq;
    logic [ADDR_W-1:0] o_flash_addr;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    always #50 i_ref_clk = ~i_ref_clk;
    assign dq_in = o_dq_oe ? o_dq_out : fl_dq;
    fesis_host #(.P_SEC_SMALL_TMO_CYC(2000), .P_SEC_LARGE_TMO_CYC(3000),
        .P_CHIP_TMO_CYC(4000)) DUT (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
        .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
        .i_small_sector(i_small_sector), .i_long_exit(i_long_exit),
        .o_cmd_ready(o_cmd_ready), .o_busy(o_busy), .o_done(o_done),
        .o_timeout(o_timeout), .o_maker_code(o_maker_code),
        .o_part_code(o_part_code), .o_flash_addr(o_flash_addr),
        .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .i_dq_in(dq_in),
        .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n));
    fesis_flash_model FL (.i_addr(o_flash_addr), .i_dq(dq_in),
        .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_hang(hang), .o_dq(fl_dq));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    // hand one request over, then wait for done or timeout
    task automatic run_op(input fesis_op_t op, input logic [ADDR_W-1:0] a,
        input logic sm, input logic lx);
        int n;
        n = 0;
        while (o_cmd_ready !== 1'b1 && n < 200) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk(n < 200, "host never ready");
        i_cmd_op = op;
        i_cmd_addr = a;
        i_small_sector = sm;
        i_long_exit = lx;
        i_cmd_valid = 1'b1;
        @(negedge i_ref_clk);
        i_cmd_valid = 1'b0;
        saw_busy = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && o_timeout !== 1'b1 && n < 9000) begin
            @(negedge i_ref_clk);
            saw_busy |= (o_busy === 1'b1);
            n++;
        end
        chk(n < 9000, "request never finished");
    endtask : run_op
    // whole-array erase polled to the end
    task automatic t_chip;
        run_op(OP_CHIP_ERASE, 19'h00000, 1'b0, 1'b0);
        chk(o_done === 1'b1 && saw_busy, "chip erase not done");
        chk(FL.last_kind === 8'h10, "chip erase not seen");
        chk(FL.busy_left == 0, "done before erase ended");
    endtask : t_chip
    // sector erase hits only the requested sector
    task automatic t_sector(input logic sm, input logic [ADDR_W-1:0] a);
        run_op(OP_SECTOR_ERASE, a, sm, 1'b0);
        chk(o_done === 1'b1 && o_timeout === 1'b0, "sector not done");
        chk(FL.last_kind === 8'h30, "sector erase not seen");
        chk(FL.last_addr[18:12] === a[18:12], "wrong sector");
        chk(FL.busy_left == 0, "done while busy");
    endtask : t_sector
    // identification read with either exit form
    task automatic t_id(input logic lx);
        run_op(OP_READ_ID, 19'h00000, 1'b0, lx);
        chk(o_maker_code === 16'h00a5, "maker code");
        chk(o_part_code === 16'h005a, "part code");
        chk(FL.id_mode === 1'b0, "id mode not left");
    endtask : t_id
    // lockdown sequence and a device that never finishes
    task automatic t_lock_hang;
        run_op(OP_LOCKDOWN, 19'h00000, 1'b0, 1'b0);
        chk(FL.lock_on === 1'b1, "lockdown not enabled");
        hang = 1'b1;
        run_op(OP_SECTOR_ERASE, 19'h7b000, 1'b1, 1'b0);
        chk(o_timeout === 1'b1, "stuck erase not timed out");
        hang = 1'b0;
    endtask : t_lock_hang
    initial begin
        repeat (20) @(negedge i_ref_clk);
        i_rst = 1'b0;
        @(negedge i_ref_clk);
        chk(FL.id_mode === 1'b0, "id mode at power up");
        t_chip;
        t_sector(1'b1, 19'h7a123);
        t_sector(1'b0, 19'h21000);
        t_id(1'b0);
        t_id(1'b1);
        t_lock_hang;
        print_verdict;
    end
    // cut a hang short
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            $display("[FAIL] %0t watchdog expired", $time);
            fails++;
            print_verdict;
        end
    end
endmodule : fesis_host_test

// >>> fesis_pkg.sv
package fesis_pkg;
    // bus geometry
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int CMD_ADDR_W = 12;
    localparam int CMD_DATA_W = 8;
    localparam int TMO_W = 30;
    localparam int CNT_W = 4;
    localparam int IDX_W = 3;

    // command cycle addresses and data bytes
    localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR1 = 12'h555;
    localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR2 = 12'h2aa;
    localparam logic [CMD_DATA_W-1:0] CMD_UNLOCK1 = 8'haa;
    localparam logic [CMD_DATA_W-1:0] CMD_UNLOCK2 = 8'h55;
    localparam logic [CMD_DATA_W-1:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [CMD_DATA_W-1:0] CMD_CHIP_ERASE = 8'h10;
    localparam logic [CMD_DATA_W-1:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [CMD_DATA_W-1:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [CMD_DATA_W-1:0] CMD_ID_EXIT = 8'hf0;
    localparam logic [CMD_DATA_W-1:0] CMD_LOCKDOWN = 8'h60;
    localparam logic [IDX_W-1:0] LONG_SEQ_LEN = 3'h6;
    localparam logic [IDX_W-1:0] SHORT_SEQ_LEN = 3'h3;
    localparam logic [IDX_W-1:0] EXIT_SHORT_LEN = 3'h1;

    // identification read addresses
    localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 19'h00000;
    localparam logic [ADDR_W-1:0] ID_PART_ADDR = 19'h00001;

    // status bit used for completion polling
    localparam int TOGGLE_BIT = 6;

    // reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // read and strobe timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int ACCESS_NS = 70;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_STAGES = 2;
    localparam logic [CNT_W-1:0] RD_LOW_CYC =
        CNT_W'(ACCESS_CYC + SYNC_STAGES);
    localparam int GAP_NS = 50;
    localparam int GAP_RAW = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'((GAP_RAW < 1) ? 1 : GAP_RAW);

    // erase time limits
    localparam real SEC_SMALL_MAX_S = 3.0;
    localparam real SEC_LARGE_MAX_S = 5.0;
    localparam real CHIP_TYP_S = 13.0;
    localparam real CHIP_MARGIN = 4.0;
    localparam int SEC_SMALL_MAX_CYC =
        $rtoi(SEC_SMALL_MAX_S * 1.0e9 / CLK_PERIOD_NS);
    localparam int SEC_LARGE_MAX_CYC =
        $rtoi(SEC_LARGE_MAX_S * 1.0e9 / CLK_PERIOD_NS);
    localparam int CHIP_MAX_CYC =
        $rtoi(CHIP_TYP_S * CHIP_MARGIN * 1.0e9 / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        OP_CHIP_ERASE,
        OP_SECTOR_ERASE,
        OP_READ_ID,
        OP_LOCKDOWN
    } fesis_op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WSETUP,
        ST_WLOW,
        ST_WHIGH,
        ST_RLOW,
        ST_RGAP,
        ST_DONE
    } fesis_state_t;

    typedef enum logic [2:0] {
        PH_CMD,
        PH_POLL,
        PH_ID_MAKER,
        PH_ID_PART,
        PH_EXIT
    } fesis_phase_t;
endpackage : fesis_pkg
